// ==== rtl/ucbrp_read_port.sv ====
// upstream cell bus read port, sampled on the system clock
`timescale 1ns/1ps
// limitations: outputs lag the read clock pin by about three system
// clocks, so the system clock must run well above the read clock.
// the protocol select is synced like any pin but must stay put while
// cells move; a change mid-cell leaves the staged words meaningless.
// buffer words are taken show-ahead: bufWord must be valid before a
// read clock rise is detected.
module ucbrp_read_port #(
  parameter bit PARITY_ODD = ucbrp_pkg::PARITY_ODD_RST
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic upstreamReadClock,
  input wire logic upstream_protocol_select,
  input wire logic [ucbrp_pkg::ADDR_W-1:0] upstream_poll_address,
  input wire logic upstream_read_enable_n,
  input wire logic [ucbrp_pkg::ADDR_W-1:0] device_identification_address,
  input wire logic cellQueued,
  input wire logic [ucbrp_pkg::WORD_W-1:0] bufWord,
  input wire logic bufLastWord,
  output logic bufRead,
  output logic [ucbrp_pkg::WORD_W-1:0] upstream_word_bus,
  output logic upstream_word_parity,
  output logic upstream_start_of_cell,
  output logic upstream_start_of_transfer,
  output logic busOe,
  output logic upstream_cell_available,
  output logic cellAvailOe
);
  typedef struct packed {
    // pin synchronisers, then device select and cell position
    logic clkMeta;
    logic clkS;
    logic clkPrev;
    logic renMeta;
    logic renS;
    logic protMeta;
    logic protS;
    logic [ucbrp_pkg::ADDR_W-1:0] adrMeta;
    logic [ucbrp_pkg::ADDR_W-1:0] adrS;
    logic [ucbrp_pkg::ADDR_W-1:0] idMeta;
    logic [ucbrp_pkg::ADDR_W-1:0] idS;
    logic selected;
    ucbrp_pkg::ucbrp_pos_e pos;
    // base output stage
    logic aDrive;
    logic [ucbrp_pkg::WORD_W-1:0] aWord;
    logic aFirst;
    logic aSecond;
    logic aPar;
    // extended output stage
    logic bDrive;
    logic [ucbrp_pkg::WORD_W-1:0] bWord;
    logic bFirst;
    logic bSecond;
    logic bPar;
    // poll answer stages
    logic pollA;
    logic availA;
    logic pollB;
    logic availB;
  } ucbrp_state_s;

  // enable taken as high so leaving reset never looks like a read
  localparam ucbrp_state_s STATE_RST = '{
    clkMeta: 1'b0,
    clkS: 1'b0,
    clkPrev: 1'b0,
    renMeta: 1'b1,
    renS: 1'b1,
    protMeta: 1'b0,
    protS: 1'b0,
    adrMeta: ucbrp_pkg::ADDR_RST,
    adrS: ucbrp_pkg::ADDR_RST,
    idMeta: ucbrp_pkg::ADDR_RST,
    idS: ucbrp_pkg::ADDR_RST,
    selected: 1'b0,
    pos: ucbrp_pkg::POS_FIRST,
    aDrive: 1'b0,
    aWord: ucbrp_pkg::WORD_RST,
    aFirst: 1'b0,
    aSecond: 1'b0,
    aPar: 1'b0,
    bDrive: 1'b0,
    bWord: ucbrp_pkg::WORD_RST,
    bFirst: 1'b0,
    bSecond: 1'b0,
    bPar: 1'b0,
    pollA: 1'b0,
    availA: 1'b0,
    pollB: 1'b0,
    availB: 1'b0
  };

  ucbrp_state_s s;
  ucbrp_state_s next_s;
  // combinational helpers
  logic rise;
  logic match;
  logic doRead;

  always_comb begin
    next_s = s;
    rise = 1'b0;
    match = 1'b0;
    doRead = 1'b0;
    if (clkEn) begin
      // async pins: two flops before any use; read clock rides alongside
      next_s.clkMeta = upstreamReadClock;
      next_s.clkS = s.clkMeta;
      next_s.clkPrev = s.clkS;
      next_s.renMeta = upstream_read_enable_n;
      next_s.renS = s.renMeta;
      next_s.protMeta = upstream_protocol_select;
      next_s.protS = s.protMeta;
      next_s.adrMeta = upstream_poll_address;
      next_s.adrS = s.adrMeta;
      next_s.idMeta = device_identification_address;
      next_s.idS = s.idMeta;
      rise = s.clkS & ~s.clkPrev;
      match = s.adrS == s.idS;
      doRead = ~s.renS & s.selected &
        (s.pos != ucbrp_pkg::POS_FIRST || cellQueued);

      // all bus state moves only on a detected read clock rise
      if (rise) begin
        next_s.pollA = match;
        next_s.availA = cellQueued;
        next_s.pollB = s.pollA;
        next_s.availB = s.availA;
        next_s.bDrive = s.aDrive;
        next_s.bWord = s.aWord;
        next_s.bFirst = s.aFirst;
        next_s.bSecond = s.aSecond;
        next_s.bPar = s.aPar;
        if (doRead) begin
          next_s.aDrive = 1'b1;
          next_s.aWord = bufWord;
          next_s.aPar = (^bufWord) ^ PARITY_ODD;
          next_s.aFirst = s.pos == ucbrp_pkg::POS_FIRST;
          next_s.aSecond = s.pos == ucbrp_pkg::POS_SECOND;
          if (bufLastWord) begin
            next_s.pos = ucbrp_pkg::POS_FIRST;
            if (s.protS) begin
              next_s.selected = 1'b0;
            end
          end else if (s.pos == ucbrp_pkg::POS_FIRST) begin
            next_s.pos = ucbrp_pkg::POS_SECOND;
          end else begin
            next_s.pos = ucbrp_pkg::POS_REST;
          end
        end else begin
          next_s.aDrive = 1'b0;
          next_s.aFirst = 1'b0;
          next_s.aSecond = 1'b0;
          if (s.renS) begin
            if (s.protS && s.pos != ucbrp_pkg::POS_FIRST) begin
              next_s.selected = s.selected;
            end else begin
              next_s.selected = match;
            end
          end
        end
      end
    end
  end

  // the freeze lives in the next-state logic, not here
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      s <= STATE_RST;
    end else begin
      s <= next_s;
    end
  end

  // advance with the latch
  // combinational so a frozen pulse can never be replayed after clkEn
  assign bufRead = rise & doRead;

  always_comb begin
    if (s.protS) begin
      upstream_word_bus = s.bWord;
      upstream_word_parity = s.bPar;
      busOe = s.bDrive;
      upstream_start_of_cell = s.bSecond;
      upstream_start_of_transfer = s.bFirst;
      cellAvailOe = s.pollB;
      upstream_cell_available = s.availB;
    end else begin
      upstream_word_bus = s.aWord;
      upstream_word_parity = s.aPar;
      busOe = s.aDrive;
      upstream_start_of_cell = s.aFirst;
      // base drives the transfer mark low
      upstream_start_of_transfer = 1'b0;
      // poll answer without the extra stage
      cellAvailOe = s.pollA;
      upstream_cell_available = s.availA;
    end
  end
endmodule // ucbrp_read_port

// ==== rtl/ucbrp_pkg.sv ====
// shared constants and types of the upstream cell bus read port
package ucbrp_pkg;
  localparam int ADDR_W = 5;
  localparam int WORD_W = 16;
  localparam int READ_CLK_MAX_MHZ = 52;
  localparam int CELL_WORDS_MIN = 27;
  localparam int CELL_WORDS_MAX = 29;
  localparam logic PARITY_ODD_RST = 1'b1;
  localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_RST = 5'h00;

  typedef enum logic [1:0] {
    POS_FIRST,
    POS_SECOND,
    POS_REST
  } ucbrp_pos_e;
endpackage

// ==== bench/ucbrp_chk_assertions.sv ====
// assertions on the read port pins
`timescale 1ns/1ps
module ucbrp_chk #(parameter bit PARITY_ODD = 1'b1) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic upstreamReadClock,
  input wire logic upstream_protocol_select,
  input wire logic bufRead,
  input wire logic [15:0] upstream_word_bus,
  input wire logic upstream_word_parity,
  input wire logic upstream_start_of_cell,
  input wire logic upstream_start_of_transfer,
  input wire logic busOe,
  input wire logic cellAvailOe
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  rst_quiet_a: assert property (
    $fell(sys_rst) |-> (!busOe && !cellAvailOe) [*3]) else $error("oe");
  // outputs only move a few cycles after a read clock rise
  oe_edge_a: assert property (
    $changed(busOe) |-> $past(upstreamReadClock, 2)) else $error("oe time");
  word_edge_a: assert property (
    !$past(upstreamReadClock, 2) |-> $stable(upstream_word_bus))
    else $error("word time");
  read_gap_a: assert property (
    bufRead |=> !bufRead [*8]) else $error("read gap");
  read_shown_a: assert property (
    bufRead |-> ##[0:40] busOe) else $error("read hidden");
  base_sot_a: assert property (
    busOe && !upstream_protocol_select |-> !upstream_start_of_transfer)
    else $error("sot");
  mark_excl_a: assert property (
    busOe && upstream_start_of_transfer |-> !upstream_start_of_cell)
    else $error("soc");
  parity_ok_a: assert property (
    busOe |-> ^{upstream_word_bus, upstream_word_parity} == PARITY_ODD)
    else $error("parity");
endmodule // ucbrp_chk
bind ucbrp_read_port ucbrp_chk #(.PARITY_ODD(PARITY_ODD)) u_chk (.clk_sys,
  .sys_rst, .upstreamReadClock, .upstream_protocol_select, .bufRead,
  .upstream_word_bus, .upstream_word_parity, .upstream_start_of_cell,
  .upstream_start_of_transfer, .busOe, .cellAvailOe);

// ==== bench/ucbrp_tm_model.sv ====
// traffic manager model driving the poll and read pins
`timescale 1ns/1ps
module ucbrp_tm_model (
  output logic rclk,
  output logic [4:0] adr,
  output logic renN
);
  initial begin
    rclk = 1'b0;
    adr = 5'h15;
    renN = 1'b1;
  end
  // one 125 ns period per call
  // clock stands still between calls; pins move 1 ns into the low phase so the
  // next rise samples them with no race against the sync flops
  task automatic cyc(input logic [4:0] a, input logic r);
    rclk = 1'b1;
    #62.5 rclk = 1'b0;
    #1;
    adr = a;
    renN = r;
    #61.5;
  endtask
endmodule // ucbrp_tm_model

// ==== bench/testbench.sv ====
// bench for the upstream cell bus read port
`timescale 1ns/1ps
module testbench;
  localparam logic [4:0] ID = 5'h0a;
  localparam logic [4:0] OTH = 5'h15;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic protSel = 1'b0;
  logic full = 1'b0;
  logic [15:0] wp;
  int error_cnt = 0;
  int compares = 0;
  int cycles = 0;
  wire logic rclk, renN, bufRead, par, soc, sot, busOe, avail, availOe;
  wire logic [4:0] adr;
  wire logic [15:0] word;
  always #2 clk_sys = ~clk_sys;
  ucbrp_tm_model u_tm (.rclk(rclk), .adr(adr), .renN(renN));
  ucbrp_read_port u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .clkEn(1'b1), .upstreamReadClock(rclk), .upstream_protocol_select(protSel),
    .upstream_poll_address(adr), .upstream_read_enable_n(renN),
    .device_identification_address(ID), .cellQueued(full),
    .bufWord(16'ha500 + wp), .bufLastWord(wp[1:0] == 2'h3),
    .bufRead(bufRead), .upstream_word_bus(word), .upstream_word_parity(par),
    .upstream_start_of_cell(soc), .upstream_start_of_transfer(sot),
    .busOe(busOe), .upstream_cell_available(avail), .cellAvailOe(availOe));
  // four-word cells stand in for full cells
  always_ff @(posedge clk_sys or posedge sys_rst)
    if (sys_rst)
      wp <= 16'h0;
    else if (bufRead)
      wp <= wp + 16'h1;
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("FAIL %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic word_chk(logic [15:0] k);
    chk("oe", 1, busOe);
    chk("word", 16'ha500 + k, word);
    chk("par", ~^(16'ha500 + k), par);
    chk("soc", k[1:0] == {1'b0, protSel}, soc);
    chk("sot", protSel && k[1:0] == 2'h0, sot);
  endtask
  task automatic restart(logic p, logic f);
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    protSel <= p;
    full <= f;
    repeat (4) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (8) @(posedge clk_sys);
  endtask
  task automatic base_run();
    u_tm.cyc(ID, 1'b1);
    u_tm.cyc(ID, 1'b1);
    chk("availOe", 1, availOe);
    chk("avail0", 0, avail);
    @(posedge clk_sys);
    full <= 1'b1;
    u_tm.cyc(ID, 1'b0);
    chk("avail1", 1, avail);
    // own address kept on the bus while reading
    for (int i = 0; i < 6; i++) begin
      u_tm.cyc(ID, i == 5);
      word_chk(16'(i));
    end
    // other address only after reading stops, two words into the second cell
    u_tm.cyc(OTH, 1'b1);
    chk("oeIdle", 0, busOe);
    u_tm.cyc(OTH, 1'b1);
    chk("availOff", 0, availOe);
    chk("pos", 6, wp);
  endtask
  task automatic ext_run();
    int ex[7] = '{9, 0, 1, 9, 2, 3, 9};
    u_tm.cyc(ID, 1'b1);
    u_tm.cyc(ID, 1'b0);
    for (int i = 0; i < 7; i++) begin
      u_tm.cyc(i == 1 ? OTH : ID, i == 1);
      if (ex[i] == 9)
        chk("oeExt", 0, busOe);
      else
        word_chk(16'(ex[i]));
    end
    chk("posExt", 4, wp);
  endtask
  task automatic tally_and_finish();
    if (error_cnt == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    restart(1'b0, 1'b0);
    base_run();
    restart(1'b1, 1'b1);
    ext_run();
    tally_and_finish();
  end
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
endmodule // testbench
